// *** verilog/psc_power_sequence_control.sv ***
// Supply sequencing, low power mode and reset/fail control
//
// Functional notes
// [RQ1] Order strap low: core first up, last down
// [RQ2] Core default 1.5 V or 1.6 V by strap
// [RQ3] I/O default 3.0 V or 3.3 V by strap
// [RQ4] Sleep entry on rising edge of request AND allow
// [RQ5] Request pin ignored while allow bit clear
// [RQ6] Sleep lowers core to preset or disables it
// [RQ7] Exit on pin low, allow cleared, button, restart
// [RQ8] Re-entry on a new rising edge
// [RQ9] Button exit restores pre-sleep core voltage
// [RQ10] Button debounced, raises maskable interrupt
// [RQ11] Warm restart resets processor when core regulates
// [RQ12] Warm restart keeps settings, only leaves sleep; the code also starts a power-up from PSC_WAIT on it
// [RQ13] Cover loss raises interrupt, pulls fail low
// [RQ14] Cover loss: converters off, linears reduced
// [RQ15] Power-on reset low during start, follows rail
// [RQ16] Power-on reset released after fixed delay
// [RQ17] Warm restart gives timed processor reset pulse
// [RQ18] Processor reset forces sleep exit
// [RQ19] Processor reset held while power-on reset low
// [RQ20] Fail low on undervoltage, overtemp or cover loss
// [RQ21] Fail held low while power-on reset low
// [RQ22] Cover filter takes 56 ms
// [RQ23] Undervoltage: fail, delay, ordered shutdown
// [RQ24] Sleep request with supply disabled shuts down
// [RQ25] Debounce by saturating stable-level counters; the code's counters clear to zero when a level is accepted
// [RQ26] Open-drain outputs are pull-low enables
//
// The implementer's own choices: strobed register access and the register offsets.
`include "psc_power_seq_regs.svh"

module psc_power_sequence_control #(
   parameter int unsigned COVER_FILTER_CYC = `PSC_COVER_FILTER_MS * `PSC_CLK_KHZ,
   parameter int unsigned PIN_FILTER_CYC = `PSC_PIN_FILTER_MS * `PSC_CLK_KHZ,
   parameter int unsigned POR_DELAY_CYC = `PSC_POR_DELAY_MS * `PSC_CLK_KHZ,
   parameter int unsigned PROC_RST_CYC = `PSC_PROC_RST_US * `PSC_CLK_MHZ,
   parameter int unsigned FAIL_DELAY_CYC = `PSC_FAIL_DELAY_US * `PSC_CLK_MHZ
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire psc_pkg::psc_pins_t pins,
   output psc_pkg::psc_drive_t drive
);

   psc_pkg::psc_regs_t q;
   psc_pkg::psc_regs_t n;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [23:0] filterLimit(input int unsigned ch);
      filterLimit = (ch == 2) ? 24'(COVER_FILTER_CYC) : 24'(PIN_FILTER_CYC);
   endfunction

   function automatic logic isPowered(input psc_pkg::psc_state_t s);
      isPowered = (s == psc_pkg::PSC_RAMP_FIRST) || (s == psc_pkg::PSC_RAMP_SECOND) ||
                  (s == psc_pkg::PSC_POR_WAIT) || (s == psc_pkg::PSC_ON) ||
                  (s == psc_pkg::PSC_SLEEP);
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [2:0] raw;
      logic btnRise;
      logic warmRise;
      logic coverFall;
      logic sleepAnd;
      logic sleepRise;
      logic fault;
      logic firstGood;
      logic secondGood;
      raw = '0;
      btnRise = 1'b0;
      warmRise = 1'b0;
      coverFall = 1'b0;
      sleepAnd = 1'b0;
      sleepRise = 1'b0;
      fault = 1'b0;
      firstGood = 1'b0;
      secondGood = 1'b0;
      n = q;
      n.rdData = 8'h00;

      // Two-stage synchroniser on every pin
      n.sync1 = pins;
      n.sync2 = q.sync1;

      // Debounce: level accepted only after full stable count
      raw[0] = q.sync2.pushButtonWake;
      raw[1] = ~q.sync2.warmRestartInN;
      raw[2] = q.sync2.coverPresent;
      for (int unsigned i = 0; i < 3; i++) begin
         if (raw[i] == q.db[i]) begin
            n.dbCnt[i] = 24'h000000; // RQ25
         end else if (q.dbCnt[i] >= filterLimit(i) - 24'h000001) begin
            n.db[i] = raw[i]; // RQ25 RQ22
            n.dbCnt[i] = 24'h000000;
         end else begin
            n.dbCnt[i] = q.dbCnt[i] + 24'h000001;
         end
      end
      btnRise = n.db[0] & ~q.db[0]; // RQ10
      warmRise = n.db[1] & ~q.db[1];
      coverFall = ~n.db[2] & q.db[2];

      // Allow bit gates the request pin entirely
      sleepAnd = q.sync2.deepSleepRequest & q.ctrl[`PSC_CTRL_SLEEP_ALLOW]; // RQ5
      n.sleepAndPrev = sleepAnd;
      sleepRise = sleepAnd & ~q.sleepAndPrev; // RQ4 RQ8
      fault = q.sync2.supplyUnderVoltage | q.sync2.overTempWarn;

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (regWr) begin
         case (regAddr)
            `PSC_ADDR_CTRL: n.ctrl = regWrData[2:0];
            `PSC_ADDR_SLEEP_CORE: n.sleepCore = regWrData[6:0];
            `PSC_ADDR_CORE_V: n.coreV = regWrData[6:0];
            `PSC_ADDR_IO_V: n.ioV = regWrData[6:0];
            `PSC_ADDR_EVENTS: n.events = q.events & ~regWrData[1:0];
            `PSC_ADDR_MASK: n.mask = regWrData[1:0];
            default: n.ctrl = n.ctrl;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (btnRise) begin
         n.events[`PSC_EV_BUTTON] = 1'b1; // RQ10
      end
      if (coverFall) begin
         n.events[`PSC_EV_COVER] = 1'b1; // RQ13
      end

      // ----------------------------------------
      // Register reads, data in the following cycle
      // ----------------------------------------
      if (regRd) begin
         case (regAddr)
            `PSC_ADDR_CTRL: n.rdData = {5'h00, q.ctrl};
            `PSC_ADDR_SLEEP_CORE: n.rdData = {1'b0, q.sleepCore};
            `PSC_ADDR_CORE_V: n.rdData = {1'b0, q.coreV};
            `PSC_ADDR_IO_V: n.rdData = {1'b0, q.ioV};
            `PSC_ADDR_STATUS: n.rdData = {q.drive.supplyFailPullLow,
               q.drive.processorResetPullLow, q.porLow, q.db[2], 4'(q.state)};
            `PSC_ADDR_EVENTS: n.rdData = {6'h00, q.events};
            `PSC_ADDR_MASK: n.rdData = {6'h00, q.mask};
            default: n.rdData = 8'h00;
         endcase
      end

      // ----------------------------------------
      // Sequencer
      // ----------------------------------------
      // First-up rail per captured order strap
      firstGood = q.orderIo ? q.sync2.ioRailGood : q.sync2.coreRailGood; // RQ1
      secondGood = q.orderIo ? q.sync2.coreRailGood : q.sync2.ioRailGood;
      case (q.state)
         psc_pkg::PSC_OFF, psc_pkg::PSC_WAIT: begin
            n.coreConv = 1'b0;
            n.ioConv = 1'b0;
            if (q.db[2] && !fault && (q.state == psc_pkg::PSC_OFF || q.autoRestart ||
                btnRise || warmRise)) begin
               if (!q.strapsDone) begin
                  // Straps taken once, long after reset release
                  n.strapsDone = 1'b1;
                  n.orderIo = q.sync2.supplyOrderSelect; // RQ1
                  n.coreV = q.sync2.coreVoltageDefaultStrap ?
                            `PSC_CORE_V_HIGH : `PSC_CORE_V_LOW; // RQ2
                  n.ioV = q.sync2.ioVoltageDefaultStrap ?
                          `PSC_IO_V_HIGH : `PSC_IO_V_LOW; // RQ3
               end
               n.state = psc_pkg::PSC_RAMP_FIRST;
            end
         end
         psc_pkg::PSC_RAMP_FIRST: begin
            if (q.orderIo) begin
               n.ioConv = 1'b1; // RQ1
            end else begin
               n.coreConv = 1'b1; // RQ1
            end
            if (firstGood) begin
               n.state = psc_pkg::PSC_RAMP_SECOND;
            end
         end
         psc_pkg::PSC_RAMP_SECOND: begin
            n.coreConv = 1'b1;
            n.ioConv = 1'b1;
            if (secondGood) begin
               n.state = psc_pkg::PSC_POR_WAIT;
            end
         end
         psc_pkg::PSC_POR_WAIT: begin
            if (!q.porLow) begin
               n.state = psc_pkg::PSC_ON;
            end
         end
         psc_pkg::PSC_ON: begin
            if (sleepRise) begin
               if (!q.ctrl[`PSC_CTRL_SUPPLY_EN]) begin
                  n.autoRestart = 1'b0; // RQ24
                  n.state = psc_pkg::PSC_DOWN_FIRST;
               end else begin
                  n.savedCore = q.coreV; // RQ9
                  n.state = psc_pkg::PSC_SLEEP; // RQ4
               end
            end
         end
         psc_pkg::PSC_SLEEP: begin
            if (q.drive.processorResetPullLow || !sleepAnd || btnRise || warmRise) begin
               n.state = psc_pkg::PSC_ON; // RQ7 RQ12 RQ18
            end
            if (btnRise) begin
               n.coreV = q.savedCore; // RQ9
            end
         end
         psc_pkg::PSC_FAIL_DELAY: begin
            // Grace time for the processor after fail goes low
            if (q.failCnt >= 24'(FAIL_DELAY_CYC) - 24'h000001) begin
               n.state = psc_pkg::PSC_DOWN_FIRST; // RQ23
            end else begin
               n.failCnt = q.failCnt + 24'h000001;
            end
         end
         psc_pkg::PSC_DOWN_FIRST: begin
            // Last-up rail goes down first
            if (q.orderIo) begin
               n.coreConv = 1'b0; // RQ1 RQ23 RQ24
            end else begin
               n.ioConv = 1'b0; // RQ1 RQ23 RQ24
            end
            n.state = psc_pkg::PSC_DOWN_SECOND;
         end
         psc_pkg::PSC_DOWN_SECOND: begin
            n.coreConv = 1'b0;
            n.ioConv = 1'b0;
            n.state = psc_pkg::PSC_WAIT;
         end
         default: n.state = psc_pkg::PSC_OFF;
      endcase

      // Faults override any powered state
      if (isPowered(q.state) || q.state == psc_pkg::PSC_FAIL_DELAY) begin
         if (!n.db[2]) begin
            n.autoRestart = 1'b1;
            n.state = psc_pkg::PSC_DOWN_FIRST; // RQ14
         end else if (fault && q.state != psc_pkg::PSC_FAIL_DELAY) begin
            n.autoRestart = 1'b1;
            n.failCnt = 24'h000000;
            n.state = psc_pkg::PSC_FAIL_DELAY; // RQ23
         end
      end

      // ----------------------------------------
      // Power-on reset and processor reset
      // ----------------------------------------
      if (!(q.state == psc_pkg::PSC_POR_WAIT || q.state == psc_pkg::PSC_ON ||
            q.state == psc_pkg::PSC_SLEEP) || !q.sync2.linearRailOneGood) begin
         n.porCnt = 24'h000000; // RQ15
         n.porLow = 1'b1; // RQ15
      end else if (q.porCnt >= 24'(POR_DELAY_CYC) - 24'h000001) begin
         n.porLow = 1'b0; // RQ16
      end else begin
         n.porCnt = q.porCnt + 24'h000001; // RQ16
      end
      if (warmRise && q.sync2.coreRailGood) begin
         n.rstCnt = 24'(PROC_RST_CYC); // RQ11 RQ17
      end else if (q.rstCnt != 24'h000000) begin
         n.rstCnt = q.rstCnt - 24'h000001; // RQ17
      end

      // ----------------------------------------
      // Pin drive, all from flip-flops
      // ----------------------------------------
      n.drive.coreEnable = n.coreConv & ~(n.state == psc_pkg::PSC_SLEEP &&
                           n.ctrl[`PSC_CTRL_SLEEP_CORE_OFF]); // RQ6
      n.drive.ioEnable = n.ioConv;
      n.drive.coreRailCode = (n.state == psc_pkg::PSC_SLEEP) ? n.sleepCore : n.coreV; // RQ6
      n.drive.ioRailCode = n.ioV;
      n.drive.linearReduced = ~n.db[2] | (n.state == psc_pkg::PSC_WAIT); // RQ14
      n.drive.powerOnResetPullLow = n.porLow; // RQ26
      n.drive.processorResetPullLow = n.porLow | (n.rstCnt != 24'h000000); // RQ19 RQ26
      n.drive.supplyFailPullLow = fault | ~n.db[2] | n.porLow; // RQ13 RQ20 RQ21
      n.drive.irqPullLow = |(n.events & ~n.mask); // RQ10 RQ13
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.state <= psc_pkg::PSC_OFF;
         q.ctrl <= `PSC_CTRL_RST;
         q.sleepCore <= `PSC_SLEEP_CORE_RST;
         q.coreV <= `PSC_CORE_V_LOW;
         q.ioV <= `PSC_IO_V_LOW;
         q.mask <= `PSC_MASK_RST;
         q.porLow <= 1'b1;
         q.drive.powerOnResetPullLow <= 1'b1;
         q.drive.processorResetPullLow <= 1'b1;
         q.drive.supplyFailPullLow <= 1'b1;
         q.drive.linearReduced <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign regRdData = q.rdData;
   assign drive = q.drive;

endmodule

// *** include/psc_power_seq_regs.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef PSC_POWER_SEQ_REGS_SVH
`define PSC_POWER_SEQ_REGS_SVH

// ----------------------------------------
// Register offsets (3-bit address)
// ----------------------------------------
`define PSC_ADDR_CTRL 3'h0
`define PSC_ADDR_SLEEP_CORE 3'h1
`define PSC_ADDR_CORE_V 3'h2
`define PSC_ADDR_IO_V 3'h3
`define PSC_ADDR_STATUS 3'h4
`define PSC_ADDR_EVENTS 3'h5
`define PSC_ADDR_MASK 3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSC_CTRL_SUPPLY_EN 0
`define PSC_CTRL_SLEEP_ALLOW 1
`define PSC_CTRL_SLEEP_CORE_OFF 2
`define PSC_EV_BUTTON 0
`define PSC_EV_COVER 1

// ----------------------------------------
// Reset values; voltages are codes in 50 mV steps
// ----------------------------------------
`define PSC_CTRL_RST 3'h1
`define PSC_SLEEP_CORE_RST 7'h14
`define PSC_MASK_RST 2'h0
`define PSC_CORE_V_LOW 7'h1E
`define PSC_CORE_V_HIGH 7'h20
`define PSC_IO_V_LOW 7'h3C
`define PSC_IO_V_HIGH 7'h42

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSC_CLK_KHZ 100000
`define PSC_CLK_MHZ 100
`define PSC_COVER_FILTER_MS 56
`define PSC_PIN_FILTER_MS 20
`define PSC_POR_DELAY_MS 100
`define PSC_PROC_RST_US 500
`define PSC_FAIL_DELAY_US 100

`endif

// *** include/psc_pkg.sv ***
// Types shared by the power sequence controller and its bench
package psc_pkg;

   typedef enum logic [3:0] {
      PSC_OFF, PSC_RAMP_FIRST, PSC_RAMP_SECOND, PSC_POR_WAIT, PSC_ON,
      PSC_SLEEP, PSC_FAIL_DELAY, PSC_DOWN_FIRST, PSC_DOWN_SECOND, PSC_WAIT
   } psc_state_t;

   typedef struct packed {
      logic supplyOrderSelect;
      logic coreVoltageDefaultStrap;
      logic ioVoltageDefaultStrap;
      logic deepSleepRequest;
      logic pushButtonWake;
      logic warmRestartInN;
      logic coverPresent;
      logic supplyUnderVoltage;
      logic overTempWarn;
      logic coreRailGood;
      logic ioRailGood;
      logic linearRailOneGood;
   } psc_pins_t;

   typedef struct packed {
      logic coreEnable;
      logic ioEnable;
      logic [6:0] coreRailCode;
      logic [6:0] ioRailCode;
      logic linearReduced;
      logic powerOnResetPullLow;
      logic processorResetPullLow;
      logic supplyFailPullLow;
      logic irqPullLow;
   } psc_drive_t;

   typedef struct packed {
      psc_pins_t sync1;
      psc_pins_t sync2;
      logic [2:0] db;
      logic [2:0][23:0] dbCnt;
      psc_state_t state;
      logic strapsDone;
      logic orderIo;
      logic coreConv;
      logic ioConv;
      logic autoRestart;
      logic sleepAndPrev;
      logic [2:0] ctrl;
      logic [6:0] sleepCore;
      logic [6:0] coreV;
      logic [6:0] ioV;
      logic [6:0] savedCore;
      logic [1:0] events;
      logic [1:0] mask;
      logic [23:0] porCnt;
      logic porLow;
      logic [23:0] rstCnt;
      logic [23:0] failCnt;
      logic [7:0] rdData;
      psc_drive_t drive;
   } psc_regs_t;

endpackage

// *** bench/psc_power_seq_monitor.sv ***
// Port-level assertions for the power sequence controller
module psc_power_seq_monitor #(
   parameter int unsigned COVER_FILTER_CYC = 8,
   parameter int unsigned POR_DELAY_CYC = 16
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire psc_pkg::psc_pins_t pins,
   input wire psc_pkg::psc_drive_t drive
);
   // ---------------------------------
   // Run lengths of raw pin levels
   // ---------------------------------
   logic [7:0] goodCnt_q;
   logic [7:0] lowCnt_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         goodCnt_q <= 8'h00;
         lowCnt_q <= 8'h00;
      end else begin
         goodCnt_q <= pins.linearRailOneGood ? goodCnt_q + {7'h00, goodCnt_q != 8'hFF} : 8'h00;
         lowCnt_q <= pins.coverPresent ? 8'h00 : lowCnt_q + {7'h00, lowCnt_q != 8'hFF};
      end
   end
   // ---------------------------------
   // Assertions
   // ---------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence rstBody;
      drive.processorResetPullLow [*8];
   endsequence
   sequence rstEnd;
      !drive.processorResetPullLow;
   endsequence
   chk_proc_pulse: assert property (
      $rose(drive.processorResetPullLow) && !drive.powerOnResetPullLow |-> rstBody ##[1:6] rstEnd)
      else $error("processor reset pulse length wrong");
   chk_ramp_order: assert property (
      $rose(pins.supplyOrderSelect ? drive.coreEnable : drive.ioEnable)
      |-> (pins.supplyOrderSelect ? drive.ioEnable : drive.coreEnable))
      else $error("converters ramped in wrong order");
   chk_fault_fail: assert property (
      (pins.supplyUnderVoltage || pins.overTempWarn) [*5] |-> drive.supplyFailPullLow)
      else $error("fail output not low on fault");
   chk_cover_fail: assert property (
      lowCnt_q >= COVER_FILTER_CYC + 6 |-> drive.supplyFailPullLow)
      else $error("fail output not low on cover loss");
   chk_cover_down: assert property (
      lowCnt_q >= COVER_FILTER_CYC + 10 |-> !drive.coreEnable && !drive.ioEnable && drive.linearReduced)
      else $error("converters still on after cover loss");
   chk_por_delay: assert property (
      $fell(drive.powerOnResetPullLow) |-> goodCnt_q >= POR_DELAY_CYC)
      else $error("power-on reset released early");
   chk_por_proc: assert property (
      drive.powerOnResetPullLow && $past(drive.powerOnResetPullLow) |-> drive.processorResetPullLow)
      else $error("processor reset released during power-on reset");
   chk_por_fail: assert property (
      drive.powerOnResetPullLow && $past(drive.powerOnResetPullLow) |-> drive.supplyFailPullLow)
      else $error("fail released during power-on reset");
endmodule
bind psc_power_sequence_control psc_power_seq_monitor #(
   .COVER_FILTER_CYC(COVER_FILTER_CYC),
   .POR_DELAY_CYC(POR_DELAY_CYC)
) mon (
   .sys_clk(sys_clk),
   .nrst(nrst),
   .pins(pins),
   .drive(drive)
);

// *** bench/psc_far_side.sv ***
// Far-side model: rail comparators plus the bench's pin levels
module psc_far_side (
   input wire logic sys_clk,
   input wire psc_pkg::psc_pins_t req,
   input wire psc_pkg::psc_drive_t drive,
   output psc_pkg::psc_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] coreDly = 3'h0;
   logic [2:0] ioDly = 3'h0;
   // Rails take a few cycles to regulate and drop at once when disabled
   always @(posedge sys_clk) begin
      coreDly <= drive.coreEnable ? {coreDly[1:0], 1'b1} : 3'h0;
      ioDly <= drive.ioEnable ? {ioDly[1:0], 1'b1} : 3'h0;
   end
   always_comb begin
      pins = req;
      pins.coreRailGood = coreDly[2];
      pins.ioRailGood = ioDly[2];
      // Linear rail one is fed from the I/O rail
      pins.linearRailOneGood = ioDly[2];
   end
endmodule

// *** bench/test_power_sequence_control.sv ***
// Self-checking bench for the power sequence controller
module test_power_sequence_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   psc_pkg::psc_pins_t req = '{coverPresent: 1'b1, warmRestartInN: 1'b1, default: 1'b0};
   psc_pkg::psc_pins_t pins;
   psc_pkg::psc_drive_t drive;
   int n_errors = 0;
   int checks_done = 0;
   int i;
   logic [7:0] v;
   always #5 sys_clk = ~sys_clk;
   // Short counts keep the run brief
   psc_power_sequence_control #(.COVER_FILTER_CYC(8), .PIN_FILTER_CYC(4), .POR_DELAY_CYC(16),
      .PROC_RST_CYC(10), .FAIL_DELAY_CYC(6)) uut (.sys_clk(sys_clk), .nrst(nrst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .pins(pins), .drive(drive));
   psc_far_side far (.sys_clk(sys_clk), .req(req), .drive(drive), .pins(pins));
   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge sys_clk);
      // Step off the edge so registered outputs have settled
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      rd(a, v);
      chk(v, e);
   endtask
   task automatic ws(input logic [3:0] s);
      for (int k = 0; k < 200; k++) begin
         rd(3'h4, v);
         if (v[3:0] === s) return;
      end
      n_errors++;
      $display("[ERR] %0t state %h not reached", $time, s);
      wrap_up();
   endtask
   task automatic btn;
      @(posedge sys_clk) req.pushButtonWake <= 1'b1;
      tk(12);
      @(posedge sys_clk) req.pushButtonWake <= 1'b0;
   endtask
   // ---------------------------------
   // Tests
   // ---------------------------------
   initial begin
      tk(3);
      nrst <= 1'b1;
      #1 chk(8'(drive.powerOnResetPullLow), 8'h01);
      rc(3'h0, 8'h01);
      rc(3'h1, 8'h14);
      rc(3'h6, 8'h00);
      wr(3'h7, 8'hA5);
      rc(3'h7, 8'h00);
      ws(4'h4);
      chk(8'(drive.coreRailCode), 8'h1E);
      chk(8'(drive.ioRailCode), 8'h3C);
      rc(3'h4, 8'h14);
      $display("test powerup done");
      @(posedge sys_clk) req.deepSleepRequest <= 1'b1;
      tk(10);
      rc(3'h4, 8'h14);
      wr(3'h0, 8'h03);
      ws(4'h5);
      chk(8'(drive.coreRailCode), 8'h14);
      wr(3'h0, 8'h01);
      ws(4'h4);
      chk(8'(drive.coreRailCode), 8'h1E);
      wr(3'h0, 8'h03);
      ws(4'h5);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b0;
      ws(4'h4);
      wr(3'h2, 8'h19);
      wr(3'h0, 8'h07);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b1;
      ws(4'h5);
      tk(2);
      chk(8'(drive.coreEnable), 8'h00);
      // Target moved during sleep; button exit must bring back the pre-sleep code
      wr(3'h2, 8'h1A);
      btn();
      ws(4'h4);
      chk(8'(drive.coreRailCode), 8'h19);
      rc(3'h5, 8'h01);
      chk(8'(drive.irqPullLow), 8'h01);
      wr(3'h6, 8'h01);
      tk(2);
      chk(8'(drive.irqPullLow), 8'h00);
      wr(3'h5, 8'h01);
      wr(3'h6, 8'h00);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b0;
      wr(3'h0, 8'h03);
      $display("test sleep done");
      @(posedge sys_clk) req.deepSleepRequest <= 1'b1;
      ws(4'h5);
      @(posedge sys_clk) req.warmRestartInN <= 1'b0;
      for (i = 0; i < 40 && drive.processorResetPullLow !== 1'b1; i++) tk(1);
      chk(8'(drive.processorResetPullLow), 8'h01);
      if (i == 40) wrap_up();
      @(posedge sys_clk) req.warmRestartInN <= 1'b1;
      ws(4'h4);
      rc(3'h0, 8'h03);
      rc(3'h2, 8'h19);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b0;
      tk(20);
      chk(8'(drive.processorResetPullLow), 8'h00);
      $display("test warm done");
      for (i = 0; i < 2; i++) begin
         @(posedge sys_clk) {req.overTempWarn, req.supplyUnderVoltage} <= i ? 2'b10 : 2'b01;
         tk(5);
         chk(8'(drive.supplyFailPullLow), 8'h01);
         ws(4'h9);
         chk(8'({drive.coreEnable, drive.ioEnable}), 8'h00);
         @(posedge sys_clk) {req.overTempWarn, req.supplyUnderVoltage} <= 2'b00;
         ws(4'h4);
      end
      @(posedge sys_clk) req.coverPresent <= 1'b0;
      tk(5);
      @(posedge sys_clk) req.coverPresent <= 1'b1;
      tk(12);
      rc(3'h4, 8'h14);
      @(posedge sys_clk) req.coverPresent <= 1'b0;
      ws(4'h9);
      chk(8'({drive.linearReduced, drive.supplyFailPullLow, drive.irqPullLow}), 8'h07);
      rc(3'h5, 8'h02);
      wr(3'h5, 8'h02);
      @(posedge sys_clk) req.coverPresent <= 1'b1;
      ws(4'h4);
      $display("test faults done");
      wr(3'h0, 8'h02);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b1;
      ws(4'h9);
      chk(8'({drive.coreEnable, drive.ioEnable}), 8'h00);
      @(posedge sys_clk) req.deepSleepRequest <= 1'b0;
      wr(3'h0, 8'h01);
      tk(20);
      rd(3'h4, v);
      chk(8'(v[3:0]), 8'h09);
      btn();
      ws(4'h4);
      $display("test shutdown done");
      // Straps change only inside reset; they are latched again at the first start after release
      @(posedge sys_clk) begin
         nrst <= 1'b0;
         {req.supplyOrderSelect, req.coreVoltageDefaultStrap, req.ioVoltageDefaultStrap} <= 3'h7;
      end
      tk(3);
      nrst <= 1'b1;
      ws(4'h4);
      chk(8'(drive.coreRailCode), 8'h20);
      chk(8'(drive.ioRailCode), 8'h42);
      $display("test straps done");
      wrap_up();
   end
endmodule
